/* hdl/tmc_pkg.sv */
// tmc_pkg: register map, field layout, mode codes and counts of the timer
package tmc_pkg;
	// ----------------------------------------------------------------
	// bus and register map
	// ----------------------------------------------------------------
	localparam int ADDR_W = 12; // apb address width
	localparam int DATA_W = 32; // apb data width
	localparam logic [ADDR_W-1:0] ADDR_CTRL_A = 12'h000;
	localparam logic [ADDR_W-1:0] ADDR_CTRL_B = 12'h004;
	localparam logic [ADDR_W-1:0] ADDR_COUNT = 12'h008;
	localparam logic [ADDR_W-1:0] ADDR_CMP_A = 12'h00c;
	localparam logic [ADDR_W-1:0] ADDR_CAPTURE = 12'h010;
	localparam logic [ADDR_W-1:0] ADDR_STATUS = 12'h014;
	localparam logic [ADDR_W-1:0] ADDR_MASK = 12'h018;
	// ----------------------------------------------------------------
	// fields and reset values
	// ----------------------------------------------------------------
	localparam int CA_MODE_HI = 1; // mode low bits in control a
	localparam int CB_FILTER_BIT = 7; // noise filter enable
	localparam int CB_EDGE_BIT = 6; // capture edge select
	localparam int CB_MODE_HI = 4; // mode high bits 4:3
	localparam int CB_MODE_LO = 3;
	localparam int CB_CS_HI = 2; // clock select 2:0
	localparam logic [7:0] CTRL_RESET = 8'h00;
	localparam logic [7:0] CTRL_B_WMASK = 8'hdf; // bit 5 reads zero
	localparam int ST_W = 2; // status and mask width
	localparam int ST_OVF_BIT = 0;
	localparam int ST_CAP_BIT = 1;
	localparam logic [ST_W-1:0] ST_RESET = 2'h0;
	localparam logic [15:0] CNT_RESET = 16'h0000;
	// ----------------------------------------------------------------
	// top values
	// ----------------------------------------------------------------
	localparam logic [15:0] TOP_MAX = 16'hffff;
	localparam logic [15:0] TOP_8 = 16'h00ff;
	localparam logic [15:0] TOP_9 = 16'h01ff;
	localparam logic [15:0] TOP_10 = 16'h03ff;
	localparam logic [15:0] BOTTOM = 16'h0000;
	localparam logic [15:0] CNT_STEP = 16'h0001;
	// ----------------------------------------------------------------
	// waveform mode codes
	// ----------------------------------------------------------------
	localparam logic [3:0] MODE_NORMAL = 4'h0;
	localparam logic [3:0] MODE_PC8 = 4'h1;
	localparam logic [3:0] MODE_PC9 = 4'h2;
	localparam logic [3:0] MODE_PC10 = 4'h3;
	localparam logic [3:0] MODE_CTC_CMP = 4'h4;
	localparam logic [3:0] MODE_FAST8 = 4'h5;
	localparam logic [3:0] MODE_FAST9 = 4'h6;
	localparam logic [3:0] MODE_FAST10 = 4'h7;
	localparam logic [3:0] MODE_PFC_CAP = 4'h8;
	localparam logic [3:0] MODE_PFC_CMP = 4'h9;
	localparam logic [3:0] MODE_PC_CAP = 4'ha;
	localparam logic [3:0] MODE_PC_CMP = 4'hb;
	localparam logic [3:0] MODE_CTC_CAP = 4'hc;
	localparam logic [3:0] MODE_RSVD = 4'hd;
	localparam logic [3:0] MODE_FAST_CAP = 4'he;
	localparam logic [3:0] MODE_FAST_CMP = 4'hf;
	// ----------------------------------------------------------------
	// clock select and prescaler
	// ----------------------------------------------------------------
	localparam logic [2:0] CS_STOP = 3'h0;
	localparam logic [2:0] CS_DIV1 = 3'h1;
	localparam logic [2:0] CS_DIV8 = 3'h2;
	localparam logic [2:0] CS_DIV64 = 3'h3;
	localparam logic [2:0] CS_DIV256 = 3'h4;
	localparam logic [2:0] CS_DIV1024 = 3'h5;
	localparam logic [2:0] CS_EXT_FALL = 3'h6;
	localparam logic [2:0] CS_EXT_RISE = 3'h7;
	localparam int PRESC_W = 10; // divider counter width
	localparam logic [PRESC_W-1:0] DIV8_MASK = 10'h007;
	localparam logic [PRESC_W-1:0] DIV64_MASK = 10'h03f;
	localparam logic [PRESC_W-1:0] DIV256_MASK = 10'h0ff;
	localparam logic [PRESC_W-1:0] DIV1024_MASK = 10'h3ff;
	localparam logic [PRESC_W-1:0] PRESC_STEP = 10'h001;
	localparam int FILTER_SAMPLES = 4; // equal samples to move filter
	// ----------------------------------------------------------------
	// types
	// ----------------------------------------------------------------
	typedef enum logic [0:0] {
		TMC_DIR_UP = 1'b0,
		TMC_DIR_DOWN = 1'b1
	} tmc_dir_t;
	typedef enum logic [1:0] {
		TMC_AT_IMM = 2'b00,
		TMC_AT_TOP = 2'b01,
		TMC_AT_BOTTOM = 2'b10,
		TMC_AT_MAX = 2'b11
	} tmc_point_t;
endpackage

/* hdl/tmc_prescaler.sv */
// tmc_prescaler: clock select decode into a one-cycle count enable
`timescale 1ns/1ps
module tmc_prescaler (
	input wire logic clk,
	input wire logic rst,
	input wire logic [2:0] clock_select_field,
	input wire logic external_count_pin,
	output logic count_tick
);
	import tmc_pkg::*;

	logic [PRESC_W-1:0] div_reg; // free-running divider
	logic [PRESC_W-1:0] div_next;
	logic pin_reg; // previous count pin sample
	logic pin_next;

	// ----------------------------------------------------------------
	// divider and pin edge
	// ----------------------------------------------------------------
	// divider runs free so a prescaled rate has no reset phase per select
	always_comb begin
		div_next = div_reg + PRESC_STEP;
		pin_next = external_count_pin;
		unique case (clock_select_field)
			CS_STOP: count_tick = 1'b0;
			CS_DIV1: count_tick = 1'b1;
			CS_DIV8: count_tick = (div_reg & DIV8_MASK) == DIV8_MASK;
			CS_DIV64: count_tick = (div_reg & DIV64_MASK) == DIV64_MASK;
			CS_DIV256: count_tick = (div_reg & DIV256_MASK) == DIV256_MASK;
			CS_DIV1024: count_tick = div_reg == DIV1024_MASK;
			CS_EXT_FALL: count_tick = pin_reg & ~external_count_pin;
			CS_EXT_RISE: count_tick = ~pin_reg & external_count_pin;
		endcase
	end

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			div_reg <= '0;
			pin_reg <= 1'b0;
		end else begin
			div_reg <= div_next;
			pin_reg <= pin_next;
		end
	end

	default clocking cb @(posedge clk); endclocking
	default disable iff (rst);
	a_stop_no_tick: assert property (
		clock_select_field == CS_STOP |-> !count_tick)
		else $error("stopped timer produced a count enable");
	a_div1024_rate: assert property (
		clock_select_field == CS_DIV1024 && count_tick
		##1 clock_select_field == CS_DIV1024 [*8] |-> !count_tick)
		else $error("divide by 1024 ticked too soon");
endmodule

/* hdl/tmc_capture_filter.sv */
// tmc_capture_filter: optional majority-free noise filter on capture pin
`timescale 1ns/1ps
module tmc_capture_filter #(
	parameter int SAMPLES = tmc_pkg::FILTER_SAMPLES
) (
	input wire logic clk,
	input wire logic rst,
	input wire logic filter_enable,
	input wire logic capture_input_pin,
	output logic filtered
);
	import tmc_pkg::*;

	logic [SAMPLES-1:0] hist_reg; // newest sample in bit 0
	logic [SAMPLES-1:0] hist_next;
	logic filt_reg; // filter output
	logic filt_next;

	// ----------------------------------------------------------------
	// sample history and output
	// ----------------------------------------------------------------
	// output moves only once the whole history agrees; costs the delay
	always_comb begin
		hist_next = {hist_reg[SAMPLES-2:0], capture_input_pin};
		filt_next = filt_reg;
		if (!filter_enable) begin
			filt_next = capture_input_pin;
		end else if (&hist_next) begin
			filt_next = 1'b1;
		end else if (~|hist_next) begin
			filt_next = 1'b0;
		end
	end

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			hist_reg <= '0;
			filt_reg <= 1'b0;
		end else begin
			hist_reg <= hist_next;
			filt_reg <= filt_next;
		end
	end

	assign filtered = filt_reg;

	default clocking cb @(posedge clk); endclocking
	default disable iff (rst);
	a_filter_holds: assert property (
		filter_enable && (|hist_next) && !(&hist_next)
		|=> $stable(filtered))
		else $error("filter output moved on mixed samples");
	a_filter_delay: assert property (
		(filter_enable && capture_input_pin) [*4]
		|=> filtered)
		else $error("filter missed four equal high samples");
endmodule

/* hdl/tmc_timer16_ctrl.sv */
// tmc_timer16_ctrl: 16-bit timer mode decode, capture and apb registers
// Function
// - mode code from control a 1:0, b 4:3
// - normal/ctc modes: immediate update, overflow at max
// - fixed-top pwm modes use 8/9/10-bit tops
// - variable-top pwm modes: update and overflow points
// - filter needs four equal samples to change
// - edge select zero falling, one rising
// - capture copies counter into capture register
// - capture sets flag; interrupt only when enabled
// - capture disabled when capture register is top
// - control b layout; bit 5 reserved; reset zero
// - clock select: stop, prescaled, external edges
//
// The address map and the APB interface to the registers were chosen for this implementation.
`timescale 1ns/1ps
module tmc_timer16_ctrl (
	input wire logic clk,
	input wire logic rst,
	input wire logic [tmc_pkg::ADDR_W-1:0] paddr,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [tmc_pkg::DATA_W-1:0] pwdata,
	output logic [tmc_pkg::DATA_W-1:0] prdata,
	output logic pready,
	output logic pslverr,
	input wire logic capture_input_pin,
	input wire logic external_count_pin,
	output logic irq
);
	import tmc_pkg::*;

	// ----------------------------------------------------------------
	// state
	// ----------------------------------------------------------------
	logic [7:0] ctrl_a_reg, ctrl_a_next; // timer_control_a
	logic [7:0] ctrl_b_reg, ctrl_b_next; // timer_control_b
	logic [15:0] cmp_buf_reg, cmp_buf_next; // compare a as written
	logic [15:0] cmp_act_reg, cmp_act_next; // compare a in use
	logic [ST_W-1:0] mask_reg, mask_next; // interrupt enables
	logic [ST_W-1:0] status_reg, status_next; // sticky flags
	logic [15:0] count_reg, count_next; // counter
	tmc_dir_t dir_reg, dir_next; // slope of dual-slope modes
	logic [15:0] cap_reg, cap_next; // capture_register
	logic filt_prev_reg, filt_prev_next; // last filtered pin level
	logic [DATA_W-1:0] rdata_reg, rdata_next; // read data
	logic err_reg, err_next; // unmapped address seen

	// ----------------------------------------------------------------
	// decoded signals
	// ----------------------------------------------------------------
	logic [3:0] waveform_mode_code;
	logic [15:0] top; // current top value
	tmc_point_t upd_at; // compare update point
	tmc_point_t ovf_at; // overflow flag point
	logic dual_slope; // counts up then down
	logic cap_is_top; // capture register used as top
	logic tick; // count enable
	logic filtered; // capture pin after filter
	logic at_top, at_bottom;
	logic top_evt, bottom_evt, max_evt, ovf_evt;
	logic cap_edge, cap_evt;
	logic setup, wr;
	logic [ST_W-1:0] set_vec;

	assign setup = psel && !penable;
	assign wr = psel && penable && pwrite;

	// ----------------------------------------------------------------
	// submodules
	// ----------------------------------------------------------------
	tmc_prescaler u_presc (
		.clk(clk),
		.rst(rst),
		.clock_select_field(ctrl_b_reg[CB_CS_HI:0]),
		.external_count_pin(external_count_pin),
		.count_tick(tick)
	);

	tmc_capture_filter #(.SAMPLES(FILTER_SAMPLES)) u_filt (
		.clk(clk),
		.rst(rst),
		.filter_enable(ctrl_b_reg[CB_FILTER_BIT]),
		.capture_input_pin(capture_input_pin),
		.filtered(filtered)
	);

	// ----------------------------------------------------------------
	// mode decode
	// ----------------------------------------------------------------
	assign waveform_mode_code = {ctrl_b_reg[CB_MODE_HI:CB_MODE_LO],
		ctrl_a_reg[CA_MODE_HI:0]};

	always_comb begin
		top = TOP_MAX;
		upd_at = TMC_AT_TOP;
		ovf_at = TMC_AT_TOP;
		dual_slope = 1'b0;
		cap_is_top = 1'b0;
		unique case (waveform_mode_code)
			// reserved code runs as normal; the bench picks it to check this
			MODE_NORMAL, MODE_RSVD: begin
				upd_at = TMC_AT_IMM;
				ovf_at = TMC_AT_MAX;
			end
			MODE_CTC_CMP, MODE_CTC_CAP: begin
				top = (waveform_mode_code == MODE_CTC_CAP) ?
					cap_reg : cmp_act_reg;
				cap_is_top = waveform_mode_code == MODE_CTC_CAP;
				upd_at = TMC_AT_IMM;
				ovf_at = TMC_AT_MAX;
			end
			MODE_PC8, MODE_PC9, MODE_PC10: begin
				top = (waveform_mode_code == MODE_PC8) ? TOP_8 :
					(waveform_mode_code == MODE_PC9) ? TOP_9 : TOP_10;
				ovf_at = TMC_AT_BOTTOM;
				dual_slope = 1'b1;
			end
			MODE_FAST8, MODE_FAST9, MODE_FAST10: begin
				top = (waveform_mode_code == MODE_FAST8) ? TOP_8 :
					(waveform_mode_code == MODE_FAST9) ? TOP_9 : TOP_10;
			end
			MODE_PFC_CAP, MODE_PFC_CMP: begin
				top = (waveform_mode_code == MODE_PFC_CAP) ?
					cap_reg : cmp_act_reg;
				cap_is_top = waveform_mode_code == MODE_PFC_CAP;
				upd_at = TMC_AT_BOTTOM;
				ovf_at = TMC_AT_BOTTOM;
				dual_slope = 1'b1;
			end
			MODE_PC_CAP, MODE_PC_CMP: begin
				top = (waveform_mode_code == MODE_PC_CAP) ?
					cap_reg : cmp_act_reg;
				cap_is_top = waveform_mode_code == MODE_PC_CAP;
				ovf_at = TMC_AT_BOTTOM;
				dual_slope = 1'b1;
			end
			MODE_FAST_CAP, MODE_FAST_CMP: begin
				top = (waveform_mode_code == MODE_FAST_CAP) ?
					cap_reg : cmp_act_reg;
				cap_is_top = waveform_mode_code == MODE_FAST_CAP;
			end
		endcase
	end

	// ----------------------------------------------------------------
	// counter events
	// ----------------------------------------------------------------
	assign at_top = count_reg == top;
	assign at_bottom = count_reg == BOTTOM;
	assign top_evt = tick && at_top;
	assign bottom_evt = tick && at_bottom;
	assign max_evt = tick && count_reg == TOP_MAX;
	always_comb begin
		unique case (ovf_at)
			TMC_AT_MAX: ovf_evt = max_evt;
			TMC_AT_BOTTOM: ovf_evt = bottom_evt && dir_reg == TMC_DIR_DOWN;
			TMC_AT_TOP: ovf_evt = top_evt;
			TMC_AT_IMM: ovf_evt = 1'b0;
		endcase
	end

	// ----------------------------------------------------------------
	// capture trigger
	// ----------------------------------------------------------------
	// pin is ignored outright while the capture register sets top
	assign cap_edge = ctrl_b_reg[CB_EDGE_BIT] ?
		(filtered && !filt_prev_reg) : (!filtered && filt_prev_reg);
	assign cap_evt = cap_edge && !cap_is_top;

	// ----------------------------------------------------------------
	// counter and direction
	// ----------------------------------------------------------------
	always_comb begin
		count_next = count_reg;
		dir_next = dir_reg;
		if (tick && !dual_slope) begin
			count_next = at_top ? BOTTOM : count_reg + CNT_STEP;
			dir_next = TMC_DIR_UP;
		end else if (tick && dir_reg == TMC_DIR_UP) begin
			// turn round at top; a top of zero holds for one tick, then steps to one
			if (at_top) begin
				dir_next = TMC_DIR_DOWN;
				count_next = at_bottom ? BOTTOM : count_reg - CNT_STEP;
			end else begin
				count_next = count_reg + CNT_STEP;
			end
		end else if (tick) begin
			if (at_bottom) begin
				dir_next = TMC_DIR_UP;
				count_next = count_reg + CNT_STEP;
			end else begin
				count_next = count_reg - CNT_STEP;
			end
		end
		if (wr && paddr == ADDR_COUNT) begin
			count_next = pwdata[15:0]; // software write wins
		end
	end

	// ----------------------------------------------------------------
	// control, compare, capture and flag registers
	// ----------------------------------------------------------------
	always_comb begin
		ctrl_a_next = ctrl_a_reg;
		ctrl_b_next = ctrl_b_reg;
		cmp_buf_next = cmp_buf_reg;
		cmp_act_next = cmp_act_reg;
		mask_next = mask_reg;
		cap_next = cap_reg;
		filt_prev_next = filtered;
		if (wr && paddr == ADDR_CTRL_A) begin
			ctrl_a_next = pwdata[7:0];
		end
		if (wr && paddr == ADDR_CTRL_B) begin
			// reserved bit never stores, whatever software sends
			ctrl_b_next = pwdata[7:0] & CTRL_B_WMASK;
		end
		if (wr && paddr == ADDR_MASK) begin
			mask_next = pwdata[ST_W-1:0];
		end
		if (wr && paddr == ADDR_CMP_A) begin
			cmp_buf_next = pwdata[15:0];
			if (upd_at == TMC_AT_IMM) begin
				cmp_act_next = pwdata[15:0];
			end
		end
		// buffered compare moves only at its point in the cycle
		if ((upd_at == TMC_AT_TOP && top_evt) ||
			(upd_at == TMC_AT_BOTTOM && bottom_evt)) begin
			cmp_act_next = cmp_buf_reg;
		end
		if (wr && paddr == ADDR_CAPTURE) begin
			cap_next = pwdata[15:0];
		end
		if (cap_evt) begin
			cap_next = count_reg;
		end
		set_vec = '0;
		set_vec[ST_OVF_BIT] = ovf_evt;
		set_vec[ST_CAP_BIT] = cap_evt;
		status_next = status_reg;
		if (wr && paddr == ADDR_STATUS) begin
			status_next = status_reg & ~pwdata[ST_W-1:0];
		end
		status_next = status_next | set_vec; // set wins over clear
	end

	// ----------------------------------------------------------------
	// apb read path
	// ----------------------------------------------------------------
	// data is captured in setup so the answer is ready with no wait
	always_comb begin
		rdata_next = rdata_reg;
		err_next = err_reg;
		if (setup) begin
			rdata_next = '0;
			err_next = 1'b0;
			case (paddr)
				ADDR_CTRL_A: rdata_next[7:0] = ctrl_a_reg;
				ADDR_CTRL_B: rdata_next[7:0] = ctrl_b_reg;
				ADDR_COUNT: rdata_next[15:0] = count_reg;
				ADDR_CMP_A: rdata_next[15:0] = cmp_buf_reg;
				ADDR_CAPTURE: rdata_next[15:0] = cap_reg;
				ADDR_STATUS: rdata_next[ST_W-1:0] = status_reg;
				ADDR_MASK: rdata_next[ST_W-1:0] = mask_reg;
				default: err_next = 1'b1;
			endcase
		end
	end

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			ctrl_a_reg <= CTRL_RESET;
			ctrl_b_reg <= CTRL_RESET;
			cmp_buf_reg <= CNT_RESET;
			cmp_act_reg <= CNT_RESET;
			mask_reg <= ST_RESET;
			status_reg <= ST_RESET;
			count_reg <= CNT_RESET;
			dir_reg <= TMC_DIR_UP;
			cap_reg <= CNT_RESET;
			filt_prev_reg <= 1'b0;
			rdata_reg <= '0;
			err_reg <= 1'b0;
		end else begin
			ctrl_a_reg <= ctrl_a_next;
			ctrl_b_reg <= ctrl_b_next;
			cmp_buf_reg <= cmp_buf_next;
			cmp_act_reg <= cmp_act_next;
			mask_reg <= mask_next;
			status_reg <= status_next;
			count_reg <= count_next;
			dir_reg <= dir_next;
			cap_reg <= cap_next;
			filt_prev_reg <= filt_prev_next;
			rdata_reg <= rdata_next;
			err_reg <= err_next;
		end
	end

	// ----------------------------------------------------------------
	// outputs
	// ----------------------------------------------------------------
	assign prdata = rdata_reg;
	assign pready = 1'b1; // zero-wait slave
	assign pslverr = psel && penable && err_reg;
	assign irq = |(status_reg & mask_reg);

	// ----------------------------------------------------------------
	// checks
	// ----------------------------------------------------------------
	default clocking cb @(posedge clk); endclocking
	default disable iff (rst);
	sequence s_cap_edge;
		cap_evt;
	endsequence
	sequence s_cap_done;
		cap_reg == $past(count_reg) && status_reg[ST_CAP_BIT];
	endsequence
	a_mode_low_write: assert property (
		wr && paddr == ADDR_CTRL_A |=> waveform_mode_code[1:0] ==
		$past(pwdata[1:0]))
		else $error("mode low bits not taken from control a");
	a_normal_wrap: assert property (
		waveform_mode_code == MODE_NORMAL && max_evt &&
		!(wr && paddr == ADDR_COUNT) |=> count_reg == BOTTOM &&
		status_reg[ST_OVF_BIT])
		else $error("normal mode did not wrap with overflow");
	a_fast8_top: assert property (
		waveform_mode_code == MODE_FAST8 && tick && count_reg == TOP_8
		&& !(wr && paddr == ADDR_COUNT) |=> count_reg == BOTTOM &&
		status_reg[ST_OVF_BIT])
		else $error("fast 8-bit did not restart at top");
	a_pfc_update: assert property (
		dual_slope && upd_at == TMC_AT_BOTTOM && bottom_evt
		|=> cmp_act_reg == $past(cmp_buf_reg))
		else $error("compare not updated at bottom");
	a_capture_copy: assert property (
		s_cap_edge |=> s_cap_done)
		else $error("capture did not copy counter and set flag");
	a_capture_off: assert property (
		cap_is_top |-> !cap_evt)
		else $error("capture fired while capture register is top");
	a_rise_edge: assert property (
		ctrl_b_reg[CB_EDGE_BIT] && !cap_is_top && !filt_prev_reg &&
		filtered |-> cap_evt)
		else $error("rising edge did not trigger capture");
	a_cap_irq: assert property (
		cap_evt && mask_reg[ST_CAP_BIT] && !(wr && paddr == ADDR_MASK)
		|=> irq)
		else $error("enabled capture did not raise interrupt");
	a_rsvd_zero: assert property (
		wr && paddr == ADDR_CTRL_B |=> !ctrl_b_reg[5])
		else $error("reserved control bit stored a one");
	a_rsvd_normal: assert property (
		waveform_mode_code == MODE_RSVD |-> top == TOP_MAX &&
		!dual_slope && ovf_at == TMC_AT_MAX)
		else $error("reserved mode not run as normal");
endmodule

/* dv/tmc_cap_src.sv */
// tmc_cap_src: behavioural source that drives the capture input pin
`timescale 1ns/1ps
module tmc_cap_src (
	input wire logic clk,
	output logic capture_input_pin
);
	// idle low at start; the pin only moves just after a rising edge
	initial capture_input_pin = 1'b0;
	// ----------------------------------------------------------------
	// stimulus tasks
	// ----------------------------------------------------------------
	// excursion of n cycles, too short ones probe the filter
	task automatic pulse(input int n);
		@(posedge clk);
		capture_input_pin <= ~capture_input_pin;
		repeat (n) @(posedge clk);
		capture_input_pin <= ~capture_input_pin;
	endtask
	// single step to the other level
	task automatic step();
		@(posedge clk);
		capture_input_pin <= ~capture_input_pin;
	endtask
endmodule

/* dv/tb_top.sv */
// tb_top: self-checking bench of the timer mode and capture control
`timescale 1ns/1ps
module tb_top;
	import tmc_pkg::*;
	// ----------------------------------------------------------------
	// stimulus and observation signals
	// ----------------------------------------------------------------
	logic clk = 1'b0;
	logic rst = 1'b1;
	logic [ADDR_W-1:0] paddr = '0;
	logic psel = 1'b0;
	logic penable = 1'b0;
	logic pwrite = 1'b0;
	logic [DATA_W-1:0] pwdata = '0;
	logic [DATA_W-1:0] prdata;
	logic pready;
	logic pslverr;
	logic cap_pin;
	logic ext_pin = 1'b0;
	logic irq;
	int n_mismatch = 0;
	int checks_done = 0;
	logic [31:0] rd; // last read data
	logic err; // last error response
	logic [15:0] val; // random counter snapshot
	// pwm modes and their top values
	logic [3:0] pm [9] = '{MODE_PC8, MODE_PC9, MODE_PC10, MODE_FAST8,
		MODE_FAST9, MODE_FAST10, MODE_PFC_CMP, MODE_PC_CMP, MODE_FAST_CMP};
	logic [15:0] pt [9] = '{TOP_8, TOP_9, TOP_10, TOP_8, TOP_9, TOP_10,
		16'h0020, 16'h0020, 16'h0020};
	// modes that overflow at max, the reserved code among them
	logic [3:0] nm [3] = '{MODE_NORMAL, MODE_RSVD, MODE_CTC_CMP};
	// capture-as-top modes, pin must be ignored
	logic [3:0] cm [4] = '{MODE_PFC_CAP, MODE_PC_CAP, MODE_CTC_CAP,
		MODE_FAST_CAP};
	// prescaled divisors for clock selects 2 to 5
	int dv [4] = '{8, 64, 256, 1024};
	always #10 clk = ~clk;
	tmc_timer16_ctrl uut (.clk(clk), .rst(rst), .paddr(paddr),
		.psel(psel), .penable(penable), .pwrite(pwrite), .pwdata(pwdata),
		.prdata(prdata), .pready(pready), .pslverr(pslverr),
		.capture_input_pin(cap_pin), .external_count_pin(ext_pin),
		.irq(irq));
	tmc_cap_src src (.clk(clk), .capture_input_pin(cap_pin));
	// ----------------------------------------------------------------
	// reporting
	// ----------------------------------------------------------------
	task automatic complete_run();
		$display("mismatches %0d checks %0d", n_mismatch, checks_done);
		if (n_mismatch == 0 && checks_done > 0) begin
			$display("STATUS OK");
		end else begin
			$display("STATUS NOT OK");
		end
		$finish;
	endtask
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		checks_done++;
		if (got !== exp) begin
			n_mismatch++;
			$display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	// ----------------------------------------------------------------
	// apb master: setup, then access held until pready at an edge
	// ----------------------------------------------------------------
	task automatic apb(input logic [11:0] a, input logic w,
		input logic [31:0] d);
		int k;
		@(posedge clk);
		psel <= 1'b1;
		penable <= 1'b0;
		paddr <= a;
		pwrite <= w;
		pwdata <= d;
		@(posedge clk);
		penable <= 1'b1;
		k = 0;
		do begin
			@(posedge clk);
			k++;
		end while (pready !== 1'b1 && k < 20);
		rd = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		// a slave that never answers ends the run
		if (pready !== 1'b1) begin
			n_mismatch++;
			complete_run();
		end
	endtask
	task automatic wr(input logic [11:0] a, input logic [31:0] d);
		apb(a, 1'b1, d);
	endtask
	task automatic rdc(input logic [11:0] a, input logic [31:0] exp);
		apb(a, 1'b0, 32'h0);
		chk(rd, exp);
	endtask
	// mode split over both controls; fe is filter and edge
	task automatic setm(input logic [3:0] m, input logic [2:0] cs,
		input logic [1:0] fe);
		wr(ADDR_CTRL_A, {30'h0, m[1:0]});
		wr(ADDR_CTRL_B, {24'h0, fe, 1'b0, m[3:2], cs});
	endtask
	// counter stopped so the captured value is known exactly
	task automatic cap_try(input int n, input logic hit);
		val = 16'($urandom);
		wr(ADDR_COUNT, {16'h0, val});
		wr(ADDR_STATUS, 32'h3);
		if (n > 0) src.pulse(n);
		else src.step();
		repeat (12) @(posedge clk);
		rdc(ADDR_STATUS, {30'h0, hit, 1'b0});
		if (hit) rdc(ADDR_CAPTURE, {16'h0, val});
	endtask
	// ----------------------------------------------------------------
	// main sequence
	// ----------------------------------------------------------------
	initial begin
		void'($urandom(70));
		repeat (16) @(posedge clk);
		rst <= 1'b0;
		chk({31'h0, irq}, 32'h0);
		rdc(ADDR_CTRL_B, 32'h0);
		// every writable bit set, reserved bit kept zero by software
		wr(ADDR_CTRL_B, 32'hdf);
		rdc(ADDR_CTRL_B, 32'hdf);
		apb(12'h01c, 1'b0, 32'h0);
		chk({31'h0, err}, 32'h1);
		// capture edges, filter and interrupt
		wr(ADDR_MASK, 32'h2);
		setm(MODE_NORMAL, CS_STOP, 2'b01);
		cap_try(2, 1'b1);
		chk({31'h0, irq}, 32'h1);
		wr(ADDR_MASK, 32'h0);
		// mask register settles at the access edge; look one edge later
		@(posedge clk);
		chk({31'h0, irq}, 32'h0);
		setm(MODE_NORMAL, CS_STOP, 2'b00);
		cap_try(0, 1'b0);
		cap_try(0, 1'b1);
		setm(MODE_NORMAL, CS_STOP, 2'b11);
		cap_try(2, 1'b0);
		cap_try(6, 1'b1);
		foreach (cm[i]) begin
			setm(cm[i], CS_STOP, 2'b01);
			cap_try(2, 1'b0);
		end
		// overflow at max, reserved code runs as normal
		setm(MODE_NORMAL, CS_STOP, 2'b00);
		wr(ADDR_CMP_A, 32'h20);
		foreach (nm[i]) begin
			setm(nm[i], CS_STOP, 2'b00);
			wr(ADDR_COUNT, 32'hfffa);
			wr(ADDR_STATUS, 32'h3);
			setm(nm[i], CS_DIV1, 2'b00);
			repeat (20) @(posedge clk);
			rdc(ADDR_STATUS, 32'h1);
		end
		// pwm modes stay at or under top and flag an overflow
		foreach (pm[i]) begin
			setm(pm[i], CS_STOP, 2'b00);
			wr(ADDR_COUNT, 32'h0);
			wr(ADDR_STATUS, 32'h3);
			setm(pm[i], CS_DIV1, 2'b00);
			repeat (2400 + $urandom_range(0, 63)) @(posedge clk);
			apb(ADDR_COUNT, 1'b0, 32'h0);
			chk({31'h0, rd <= {16'h0, pt[i]}}, 32'h1);
			rdc(ADDR_STATUS, 32'h1);
		end
		// stopped clock, then external edges of each polarity
		setm(MODE_NORMAL, CS_STOP, 2'b00);
		wr(ADDR_COUNT, 32'h5);
		repeat (30) @(posedge clk);
		rdc(ADDR_COUNT, 32'h5);
		setm(MODE_NORMAL, CS_EXT_RISE, 2'b00);
		ext_pin <= 1'b1;
		repeat (8) @(posedge clk);
		rdc(ADDR_COUNT, 32'h6);
		setm(MODE_NORMAL, CS_EXT_FALL, 2'b00);
		ext_pin <= 1'b0;
		repeat (8) @(posedge clk);
		rdc(ADDR_COUNT, 32'h7);
		// ten divisor periods hold exactly ten ticks, whatever the phase
		foreach (dv[i]) begin
			setm(MODE_NORMAL, CS_STOP, 2'b00);
			wr(ADDR_COUNT, 32'h0);
			setm(MODE_NORMAL, CS_DIV8 + 3'(i), 2'b00);
			repeat (10 * dv[i] - 1) @(posedge clk);
			rdc(ADDR_COUNT, 32'ha);
		end
		complete_run();
	end
endmodule
